// file: rtl/rvt_pkg.sv
// package: register map, field layout, timing constants and states
package rvt_pkg;
  // clock rate and base time units
  localparam int unsigned CLK_FREQ_KHZ  = 200_000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned STEP_MS       = 2;
  localparam int unsigned CYCLES_PER_MS = CLK_FREQ_KHZ * TICK_MS;
  localparam int unsigned CYCLES_PER_STEP = CLK_FREQ_KHZ * STEP_MS;

  // register offsets
  localparam logic [7:0] DLY_CTL_OFFSET = 8'h17;
  localparam logic [7:0] AST_CTL_OFFSET = 8'h18;

  // reset values
  localparam logic [7:0] DLY_CTL_RESET = 8'h2d;
  localparam logic [7:0] AST_CTL_RESET = 8'h19;

  // field positions, delay/timeout/confirm register
  localparam int unsigned DELAY_TOP_BIT = 7;
  localparam int unsigned TIMEOUT_MSB   = 6;
  localparam int unsigned TIMEOUT_LSB   = 3;
  localparam int unsigned CONFIRM_MSB   = 2;
  localparam int unsigned CONFIRM_LSB   = 0;

  // field positions, assertion control register
  localparam int unsigned ENABLE_BIT    = 7;
  localparam int unsigned RESERVED_BIT  = 6;
  localparam int unsigned ASSERT_MSB    = 5;
  localparam int unsigned ASSERT_LSB    = 0;

  // step sizes of the delay and timeout codes, in ms
  localparam logic [10:0] DELAY_STEP_MS   = 11'h100;
  localparam logic [10:0] TIMEOUT_STEP_MS = 11'h080;

  // confirmation times in ms, indexed by code
  localparam logic [10:0] CONFIRM_MS_0 = 11'h064;
  localparam logic [10:0] CONFIRM_MS_1 = 11'h096;
  localparam logic [10:0] CONFIRM_MS_2 = 11'h0c8;
  localparam logic [10:0] CONFIRM_MS_3 = 11'h100;
  localparam logic [10:0] CONFIRM_MS_4 = 11'h180;
  localparam logic [10:0] CONFIRM_MS_5 = 11'h200;
  localparam logic [10:0] CONFIRM_MS_6 = 11'h280;
  localparam logic [10:0] CONFIRM_MS_7 = 11'h400;

  // validation sequence, gray coded
  typedef enum logic [1:0] {
    RVT_IDLE    = 2'b00,
    RVT_CONFIRM = 2'b01,
    RVT_DELAY   = 2'b11,
    RVT_VALID   = 2'b10
  } rvt_state_t;
endpackage : rvt_pkg

// file: rtl/rvt_tick_div.sv
// module: free-running divider giving a one-cycle tick every DIV cycles
module rvt_tick_div #(
  parameter int unsigned DIV = 200_000
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      tick
);
  logic [31:0] countReg;

  // count down, tick on wrap; a long period keeps the divider free-running
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      countReg <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (countReg == 32'h0000_0000) begin
      countReg <= 32'(DIV - 1);
      tick     <= 1'b1;
    end else begin
      countReg <= countReg - 32'h0000_0001;
      tick     <= 1'b0;
    end
  end
endmodule : rvt_tick_div

// file: rtl/rvt_ring_validation.sv
// module: ring validation timing with its two control registers
// Functional notes
// - A programmable 0/256/512/.../1792 ms delay separates validation from the valid indication.
// - The ring is over when the 128 ms-step timeout has run since the latest crossing.
// - Frequency must stay in limits for the coded confirmation time before the ring is valid.
// - With the enable bit clear no validation is applied; set, it runs in every power mode.
// - Each crossing loads the qualification timer with the assertion time; it decrements every 2 ms.
// - A crossing that finds the timer already at zero means too low a frequency and invalidates.
// - The least spacing of crossings is assertion time minus max-frequency limit, in 2 ms steps.
// - A crossing that finds the timer above the max-frequency limit means too high a frequency.
// - The two low delay bits come from the neighbouring register and join the top bit here.
module rvt_ring_validation
  import rvt_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = rvt_pkg::CYCLES_PER_MS,
  parameter int unsigned STEP_CYCLES = rvt_pkg::CYCLES_PER_STEP
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  input  wire logic [1:0] ring_delay_low_bits,
  input  wire logic [5:0] ring_max_freq_limit,
  input  wire logic       tipRingCross,
  output logic            ringValid,
  output logic            ringInvalidated,
  output logic            ringOver
);
  import rvt_pkg::*;

  logic [7:0]  dlyCtl_reg;
  logic [7:0]  astCtl_reg;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        sync3_reg;
  logic        stable_reg;
  logic        crossEvent;
  logic        msTick;
  logic        stepTick;
  logic [5:0]  qualTimer_reg;
  logic [10:0] sinceEventMs_reg;
  logic [10:0] phaseMs_reg;
  rvt_state_t  state_reg;
  rvt_state_t  state_next;
  logic        tooLow;
  logic        tooHigh;
  logic        timedOut;
  logic [10:0] confirmMs;
  logic [10:0] delayMs;
  logic [10:0] timeoutMs;
  logic        ring_validation_enable;
  logic [5:0]  assertTime;
  logic [2:0]  ring_confirm_time_code;
  logic [3:0]  ring_timeout_code;
  logic        ring_delay_top_bit;

  // field extraction
  assign ring_validation_enable = astCtl_reg[ENABLE_BIT];
  assign assertTime             = astCtl_reg[ASSERT_MSB:ASSERT_LSB];
  assign ring_delay_top_bit     = dlyCtl_reg[DELAY_TOP_BIT];
  assign ring_timeout_code      = dlyCtl_reg[TIMEOUT_MSB:TIMEOUT_LSB];
  assign ring_confirm_time_code = dlyCtl_reg[CONFIRM_MSB:CONFIRM_LSB];

  // millisecond base for confirm, delay and timeout
  rvt_tick_div #(
    .DIV (MS_CYCLES)
  ) u_ms_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (msTick)
  );

  // 2 ms step for the qualification timer
  rvt_tick_div #(
    .DIV (STEP_CYCLES)
  ) u_step_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (stepTick)
  );

  // register writes; reserved bit is held at zero whatever is written
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dlyCtl_reg <= DLY_CTL_RESET;
      astCtl_reg <= AST_CTL_RESET;
    end else if (regWrEn) begin
      if (regAddr == DLY_CTL_OFFSET) begin
        dlyCtl_reg <= regWrData;
      end
      if (regAddr == AST_CTL_OFFSET) begin
        astCtl_reg <= regWrData & ~(8'h01 << RESERVED_BIT);
      end
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      if (regAddr == DLY_CTL_OFFSET) begin
        regRdData <= dlyCtl_reg;
      end else if (regAddr == AST_CTL_OFFSET) begin
        regRdData <= astCtl_reg;
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  // three-flop synchroniser for the line-side crossing level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg  <= 1'b0;
      sync2_reg  <= 1'b0;
      sync3_reg  <= 1'b0;
      stable_reg <= 1'b0;
    end else begin
      sync1_reg <= tipRingCross;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        stable_reg <= sync3_reg;
      end
    end
  end

  // a crossing counts once, on the agreed rising change
  assign crossEvent = (sync2_reg == sync3_reg) && sync3_reg && !stable_reg;

  // qualification timer: load on each crossing, count down per step
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      qualTimer_reg <= 6'h00;
    end else if (crossEvent) begin
      qualTimer_reg <= assertTime;
    end else if (stepTick && qualTimer_reg != 6'h00) begin
      qualTimer_reg <= qualTimer_reg - 6'h01;
    end
  end

  // ms since latest crossing, saturating so a dead line stays timed out
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sinceEventMs_reg <= 11'h000;
    end else if (crossEvent) begin
      sinceEventMs_reg <= 11'h000;
    end else if (msTick && sinceEventMs_reg != 11'h7ff) begin
      sinceEventMs_reg <= sinceEventMs_reg + 11'h001;
    end
  end

  // ms spent in the current phase, cleared on every state change
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phaseMs_reg <= 11'h000;
    end else if (state_next != state_reg) begin
      phaseMs_reg <= 11'h000;
    end else if (tooLow || tooHigh) begin
      phaseMs_reg <= 11'h000;
    end else if (msTick && phaseMs_reg != 11'h7ff) begin
      phaseMs_reg <= phaseMs_reg + 11'h001;
    end
  end

  // confirmation time lookup
  always_comb begin
    unique case (ring_confirm_time_code)
      3'd0: confirmMs = CONFIRM_MS_0;
      3'd1: confirmMs = CONFIRM_MS_1;
      3'd2: confirmMs = CONFIRM_MS_2;
      3'd3: confirmMs = CONFIRM_MS_3;
      3'd4: confirmMs = CONFIRM_MS_4;
      3'd5: confirmMs = CONFIRM_MS_5;
      3'd6: confirmMs = CONFIRM_MS_6;
      3'd7: confirmMs = CONFIRM_MS_7;
    endcase
  end

  // delay joins the neighbour's low bits; timeout code 0 is not guarded
  assign delayMs = 11'({ring_delay_top_bit, ring_delay_low_bits})
                   * DELAY_STEP_MS;
  assign timeoutMs = 11'(ring_timeout_code) * TIMEOUT_STEP_MS;

  // frequency checks on a subsequent crossing; spacing window is
  assign tooLow  = crossEvent && state_reg != RVT_IDLE
                   && qualTimer_reg == 6'h00;
  assign tooHigh = crossEvent && state_reg != RVT_IDLE
                   && qualTimer_reg > ring_max_freq_limit;
  assign timedOut = state_reg != RVT_IDLE && !crossEvent
                    && sinceEventMs_reg >= timeoutMs;

  // validation sequence
  always_comb begin
    state_next = state_reg;
    if (!ring_validation_enable) begin
      state_next = RVT_IDLE;
    end else if (timedOut) begin
      state_next = RVT_IDLE;
    end else if (tooLow || tooHigh) begin
      state_next = RVT_CONFIRM;
    end else begin
      unique case (state_reg)
        RVT_IDLE: begin
          if (crossEvent) begin
            state_next = RVT_CONFIRM;
          end
        end
        RVT_CONFIRM: begin
          if (phaseMs_reg >= confirmMs) begin
            state_next = RVT_DELAY;
          end
        end
        RVT_DELAY: begin
          if (phaseMs_reg >= delayMs) begin
            state_next = RVT_VALID;
          end
        end
        RVT_VALID: begin
          state_next = RVT_VALID;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= RVT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs; with validation off the detector level passes straight on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ringValid       <= 1'b0;
      ringInvalidated <= 1'b0;
      ringOver        <= 1'b0;
    end else begin
      if (!ring_validation_enable) begin
        ringValid <= stable_reg;
      end else begin
        ringValid <= (state_next == RVT_VALID);
      end
      ringInvalidated <= ring_validation_enable
                         && (tooLow || tooHigh);
      ringOver <= ring_validation_enable && timedOut;
    end
  end
endmodule : rvt_ring_validation

// file: testbench/rvt_ring_validation_assertions.sv
// checker: port-level properties of the ring validation block
module rvt_ring_validation_chk
  import rvt_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       ringValid,
  input wire logic       ringInvalidated,
  input wire logic       ringOver
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // valid and ring-over indications start quiet after every release of reset
  chk_rst_idle: assert property ($fell(rst) |-> !ringValid && !ringOver)
    else $error("indication active after reset");
  chk_inval_pulse: assert property (ringInvalidated |=> !ringInvalidated)
    else $error("invalid pulse too long");
  chk_over_pulse: assert property (ringOver |=> !ringOver)
    else $error("ring over pulse too long");
  // two cycles of slack: the level may drop one cycle after the pulse
  chk_over_drops: assert property (ringOver |-> ##2 !ringValid)
    else $error("valid held after ring over");
  chk_inval_drops: assert property (ringInvalidated |-> ##2 !ringValid)
    else $error("valid held after invalidation");
  chk_rsv_zero: assert property (regRdEn && regAddr == AST_CTL_OFFSET
    |=> !regRdData[RESERVED_BIT]) else $error("reserved bit reads one");
  chk_unmapped_zero: assert property (regRdEn && regAddr != AST_CTL_OFFSET
    && regAddr != DLY_CTL_OFFSET |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_rd_holds: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data moved without a read");
  chk_wr_rdback: assert property (regWrEn && regAddr == DLY_CTL_OFFSET
    ##2 regRdEn && regAddr == DLY_CTL_OFFSET
    |=> regRdData == $past(regWrData, 3)) else $error("read back differs");
endmodule : rvt_ring_validation_chk

bind rvt_ring_validation rvt_ring_validation_chk i_chk (
  .sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .ringValid(ringValid), .ringInvalidated(ringInvalidated),
  .ringOver(ringOver));

// file: testbench/rvt_line_model.sv
// line-side model: emits spaced crossing events on request
module rvt_line_model (
  input  wire logic sys_clk,
  output logic      tipRingCross
);
  timeunit 1ns;
  timeprecision 1ps;
  initial tipRingCross = 1'b0;
  // four cycles high so the input filter never swallows an event
  task automatic burst(input int n, input int gap);
    repeat (n) begin
      @(negedge sys_clk);
      tipRingCross = 1'b1;
      repeat (4) @(negedge sys_clk);
      tipRingCross = 1'b0;
      repeat (gap - 5) @(negedge sys_clk);
    end
  endtask : burst
endmodule : rvt_line_model

// file: testbench/rvt_ring_validation_tb_top.sv
// testbench: register map and ring qualification scenarios
module rvt_ring_validation_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rvt_pkg::*;
  logic       sys_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic       tipRingCross, ringValid, ringInvalidated, ringOver;
  logic       rdPend = 1'b0, vPrev = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
  logic [7:0] rq[$];
  logic [7:0] eq[$];
  int         err_total = 0, checks_done = 0, seed = 57930;
  int         cycCnt = 0, vCyc = 0, t0 = 0;
  // neighbour register fields, driven from the bench like any input
  logic [1:0] lowBits = 2'b01;
  logic [5:0] maxLim = 6'h02;
  localparam int TB_MS = 10;
  // confirm code 0 plus delay code 1 at the shortened time base
  localparam int V_EXP = (int'(CONFIRM_MS_0) + int'(DELAY_STEP_MS)) * TB_MS;
  always #2.5 sys_clk = ~sys_clk;
  // short time base keeps ms figures in the low thousands of cycles
  rvt_ring_validation #(.MS_CYCLES(10), .STEP_CYCLES(20)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .ring_delay_low_bits(lowBits), .ring_max_freq_limit(maxLim),
    .tipRingCross(tipRingCross), .ringValid(ringValid),
    .ringInvalidated(ringInvalidated), .ringOver(ringOver));
  rvt_line_model i_line (.sys_clk(sys_clk), .tipRingCross(tipRingCross));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  // read strobe as the design takes it; its data has settled by the fall
  always @(posedge sys_clk) begin
    rdPend <= regRdEn;
    cycCnt <= cycCnt + 1;
  end
  // monitor at the falling edge, away from the edge that launches outputs
  always @(negedge sys_clk) begin
    if (!rst) begin
      if (rdPend) begin
        cmp(regRdData, rq.size() ? rq.pop_front() : 8'hxx);
      end
      if (ringValid && !vPrev) begin
        vCyc = cycCnt;
        cmp("V", eq.size() ? eq.pop_front() : "-");
      end
      if (ringInvalidated) begin
        cmp("I", eq.size() ? eq.pop_front() : "-");
      end
      if (ringOver) begin
        cmp("O", eq.size() ? eq.pop_front() : "-");
      end
    end
    vPrev = ringValid;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = v;
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    regRdEn = 1'b1;
    regAddr = a;
    rq.push_back(v);
    @(negedge sys_clk);
    regRdEn = 1'b0;
  endtask : rd
  // mid-run reset returns both registers to their defaults
  task automatic rstp();
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
  endtask : rstp
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  // bounded wait for all notes to be matched
  task automatic drain(input string nm, input int n);
    while (n > 0 && (rq.size() != 0 || eq.size() != 0)) begin
      @(negedge sys_clk);
      n--;
    end
    if (rq.size() != 0 || eq.size() != 0) begin
      err_total++;
      $display("wrong value at %0t: %s timed out", $time, nm);
      close_out();
    end else begin
      $display("test %s done", nm);
    end
  endtask : drain
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    rd(DLY_CTL_OFFSET, DLY_CTL_RESET);
    rd(AST_CTL_OFFSET, AST_CTL_RESET);
    rd(8'h20, 8'h00);
    repeat (4) begin
      // timeout code 0000 is never programmed, so force a nonzero code
      d = 8'($random(seed)) | 8'h08;
      wr(DLY_CTL_OFFSET, d);
      rd(DLY_CTL_OFFSET, d);
    end
    drain("registers", 40);
    // confirm 100 ms, delay 256 ms, timeout 128 ms, assertion time 5
    wr(DLY_CTL_OFFSET, 8'h08);
    // assertion time of 5 steps (100 cycles) outlasts the 70-cycle ring period
    wr(AST_CTL_OFFSET, 8'h85);
    rd(AST_CTL_OFFSET, 8'h85);
    eq.push_back("V");
    eq.push_back("O");
    t0 = cycCnt;
    i_line.burst(60, 70);
    drain("qualified ring", 2000);
    // confirm plus delay must elapse between first crossing and valid
    checks_done++;
    if (vCyc - t0 < V_EXP - 20 || vCyc - t0 > V_EXP + 40) begin
      err_total++;
      $display("wrong value at %0t: valid after %0d cycles", $time, vCyc - t0);
    end
    eq.push_back("I");
    i_line.burst(2, 30);
    drain("too high", 100);
    rstp();
    wr(DLY_CTL_OFFSET, 8'h08);
    wr(AST_CTL_OFFSET, 8'h85);
    eq.push_back("I");
    i_line.burst(2, 130);
    drain("too low", 200);
    rstp();
    // disabled: the level simply follows each crossing, no pulses
    eq.push_back("V");
    eq.push_back("V");
    i_line.burst(2, 30);
    drain("disabled", 100);
    close_out();
  end
endmodule : rvt_ring_validation_tb_top
